// ==== hw/brg_pkg.sv ====
// Constants and carrier types for the two-wire to SPI transfer bridge.
// Assumes a 50 MHz system clock and a separate, unrelated link clock.
package brg_pkg;
    // Function identifiers carried in the first message byte
    localparam logic [7:0] FN_CFG    = 8'hF0;  // Configure SPI port
    localparam logic [7:0] FN_CLR    = 8'hF1;  // Clear pending interrupt
    localparam logic [3:0] FN_XFER_HI = 4'h0;  // Upper nibble of a transfer id
    // Setting byte field positions
    localparam int CFG_RATE_LSB = 0;           // Two-bit rate select
    localparam int CFG_CPHA_BIT = 2;           // Clock phase
    localparam int CFG_CPOL_BIT = 3;           // Clock polarity
    localparam logic [7:0] CFG_RESET = 8'h00;  // Mode 0, fastest rate
    // Serial bit rates in kHz for rate codes 0..3
    localparam int RATE0_KHZ = 1843;
    localparam int RATE1_KHZ = 461;
    localparam int RATE2_KHZ = 115;
    localparam int RATE3_KHZ = 58;
    // Pin modes of a general-purpose pin
    localparam logic [1:0] PM_QUASI = 2'h0;
    localparam logic [1:0] PM_PUSH  = 2'h1;
    localparam logic [1:0] PM_INPUT = 2'h2;
    localparam logic [1:0] PM_OPEN  = 2'h3;
    // System clock and input filter timing
    localparam int CLK_MHZ   = 50;
    localparam int GLITCH_NS = 125;            // Least accepted pulse width
    localparam int GLITCH_CYC = (GLITCH_NS * CLK_MHZ + 999) / 1000;
    // Message byte from the two-wire slave front end
    typedef struct packed {
        logic       last;                      // Final byte before stop
        logic [7:0] data;                      // Byte value
    } brg_msg_s;
    // Control state of the transfer sequencer
    typedef enum logic [2:0] {
        ST_FUNC, ST_CFG, ST_XFER, ST_WAIT, ST_SKIP
    } brg_st_e;
endpackage : brg_pkg

// ==== hw/brg_bridge.sv ====
// Transfer path of a two-wire slave to SPI master bridge, with its FIFO.
// Assumes a front end that hands over decoded write bytes and drains reads.
// Summary of operation
// - SPI master, modes zero to three, bounded rate
// - Four separate slave select outputs
// - Device alone generates the serial clock
// - Data out on MOSI, in on MISO
// - First byte selects the slave select output
// - Lone F1 byte clears pending interrupt
// - Received bytes stored in order, up to BUF_DEPTH
// - One readback byte per stored byte
// - Push-pull pin drives latch value strongly
// - Input-only pin never drives, filtered input
// - Active-low interrupt after each transfer, held
// - Enable bit one makes pin general-purpose
`timescale 1ns/1ps
`default_nettype none

// Synchronous FIFO with valid/ready on both sides
module brg_fifo #(
    parameter int W = 9,
    parameter int D = 16
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    if (D < 2 || (1 << AW) != D) begin : g_bad_depth
        $error("FIFO depth must be a power of two");
    end
    logic [W-1:0] mem [D];             // Storage
    logic [AW:0]  wp_q;                // Write pointer with wrap bit
    logic [AW:0]  rp_q;                // Read pointer with wrap bit
    assign in_ready  = (wp_q - rp_q) != (AW+1)'(D);
    assign out_valid = wp_q != rp_q;
    assign out_data  = mem[rp_q[AW-1:0]];
    // Pointer update
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (in_valid && in_ready) wp_q <= wp_q + 1'b1;
            if (out_valid && out_ready) rp_q <= rp_q + 1'b1;
        end
    end
    // Storage write
    always_ff @(posedge clk) begin
        if (in_valid && in_ready) mem[wp_q[AW-1:0]] <= in_data;
    end
endmodule // brg_fifo

// Bridge top: sequencer, readback buffer, pin logic, link-clocked shifter
module brg_bridge #(
    parameter int BUF_DEPTH = 200,     // Readback buffer bytes
    parameter int FIFO_DEPTH = 16,     // Message FIFO words
    parameter int LINK_KHZ  = 20833    // Link clock rate
) (
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              link_clk,
    input  wire logic              msg_valid,
    output logic                   msg_ready,
    input  wire brg_pkg::brg_msg_s msg_in,
    output logic                   rd_valid,
    input  wire logic              rd_ready,
    output logic [7:0]             rd_data,
    output logic                   int_n,
    output logic                   busy,
    output logic                   serial_master_clock,
    output logic                   mosi,
    input  wire logic              miso,
    input  wire logic [3:0]        gpio_en,
    input  wire logic [7:0]        gpio_cfg,
    input  wire logic [3:0]        gpio_latch,
    output logic [3:0]             gpio_in,
    input  wire logic [3:0]        slave_select_n_i,
    output logic [3:0]             slave_select_n_o,
    output logic [3:0]             slave_select_n_oe
);
    if (BUF_DEPTH < 1 || BUF_DEPTH > 255) begin : g_bad_buf
        $error("Buffer depth out of range");
    end
    // Half-period counts per rate, rounded up so the rate never exceeds its figure
    localparam int HP0 = (LINK_KHZ + 2*brg_pkg::RATE0_KHZ - 1) / (2*brg_pkg::RATE0_KHZ);
    localparam int HP1 = (LINK_KHZ + 2*brg_pkg::RATE1_KHZ - 1) / (2*brg_pkg::RATE1_KHZ);
    localparam int HP2 = (LINK_KHZ + 2*brg_pkg::RATE2_KHZ - 1) / (2*brg_pkg::RATE2_KHZ);
    localparam int HP3 = (LINK_KHZ + 2*brg_pkg::RATE3_KHZ - 1) / (2*brg_pkg::RATE3_KHZ);

    // ---------------- System clock domain ----------------
    brg_pkg::brg_msg_s f_out;          // FIFO head
    logic              f_valid;        // FIFO head present
    logic              f_ready;        // Sequencer pops head
    brg_pkg::brg_st_e  st_q;           // Sequencer state
    logic [7:0]        cfg_q;          // SPI setting byte
    logic [3:0]        ss_q;           // Active slave select mask
    logic [7:0]        tx_q;           // Byte handed to shifter
    logic              last_q;         // Handed byte ends the message
    logic              req_tgl_q;      // Request toggle toward link
    logic              ack_s1_q;       // Ack synchroniser stage 1
    logic              ack_s2_q;       // Ack synchroniser stage 2
    logic              ack_seen_q;     // Last ack level consumed
    logic              ack_tgl_q;      // Ack toggle from the link domain
    logic              ack_evt;        // Byte exchange completed
    logic              int_q;          // Pending interrupt
    logic [7:0]        wr_cnt_q;       // Bytes stored in buffer
    logic [7:0]        rd_ptr_q;       // Next byte to read back
    logic [7:0]        rx_byte;        // Received byte from link
    logic [7:0]        buf_mem [BUF_DEPTH];  // Readback buffer
    logic              rd_valid_q;     // Readback byte staged
    logic [7:0]        rd_data_q;      // Staged readback byte
    logic              xfer_id;        // Head is a transfer id

    // Message FIFO; its ready backs up into the front end
    brg_fifo #(.W($bits(brg_pkg::brg_msg_s)), .D(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .arst_n    (arst_n),
        .in_valid  (msg_valid),
        .in_ready  (msg_ready),
        .in_data   (msg_in),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_out)
    );

    assign f_ready = (st_q != brg_pkg::ST_WAIT);
    assign ack_evt = (ack_s2_q != ack_seen_q);
    assign xfer_id = (f_out.data[7:4] == brg_pkg::FN_XFER_HI) && (f_out.data[3:0] != 4'h0);
    assign busy    = (st_q == brg_pkg::ST_WAIT) || (st_q == brg_pkg::ST_XFER);

    // Ack toggle synchroniser
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_s1_q   <= 1'b0;
            ack_s2_q   <= 1'b0;
            ack_seen_q <= 1'b0;
        end else begin
            ack_s1_q   <= ack_tgl_q;
            ack_s2_q   <= ack_s1_q;
            ack_seen_q <= ack_s2_q;
        end
    end

    // Message sequencer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q      <= brg_pkg::ST_FUNC;
            cfg_q     <= brg_pkg::CFG_RESET;
            ss_q      <= 4'h0;
            tx_q      <= 8'h00;
            last_q    <= 1'b0;
            req_tgl_q <= 1'b0;
        end else begin
            unique case (st_q)
                brg_pkg::ST_FUNC: if (f_valid) begin
                    if (!f_out.last && f_out.data == brg_pkg::FN_CFG) begin
                        st_q <= brg_pkg::ST_CFG;
                    end else if (!f_out.last && xfer_id) begin
                        ss_q <= f_out.data[3:0];
                        st_q <= brg_pkg::ST_XFER;
                    end else if (!f_out.last) begin
                        st_q <= brg_pkg::ST_SKIP;          // Unknown or over-long
                    end
                end
                brg_pkg::ST_CFG: if (f_valid) begin
                    cfg_q <= f_out.data;
                    st_q  <= f_out.last ? brg_pkg::ST_FUNC : brg_pkg::ST_SKIP;
                end
                brg_pkg::ST_XFER: if (f_valid) begin
                    tx_q      <= f_out.data;
                    last_q    <= f_out.last;
                    req_tgl_q <= ~req_tgl_q;
                    st_q      <= brg_pkg::ST_WAIT;
                end
                brg_pkg::ST_WAIT: if (ack_evt) begin
                    if (last_q) begin
                        ss_q <= 4'h0;
                        st_q <= brg_pkg::ST_FUNC;
                    end else begin
                        st_q <= brg_pkg::ST_XFER;
                    end
                end
                brg_pkg::ST_SKIP: if (f_valid && f_out.last) begin
                    st_q <= brg_pkg::ST_FUNC;
                end
            endcase
        end
    end

    // Interrupt flag; completion set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            int_q <= 1'b0;
        end else if (st_q == brg_pkg::ST_WAIT && ack_evt && last_q) begin
            int_q <= 1'b1;
        end else if (st_q == brg_pkg::ST_FUNC && f_valid && f_out.last
                     && f_out.data == brg_pkg::FN_CLR) begin
            int_q <= 1'b0;
        end
    end
    assign int_n = ~int_q;

    // Buffer counters; a new transfer restarts both
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_cnt_q <= 8'h00;
            rd_ptr_q <= 8'h00;
        end else if (st_q == brg_pkg::ST_FUNC && f_valid && !f_out.last && xfer_id) begin
            wr_cnt_q <= 8'h00;
            rd_ptr_q <= 8'h00;
        end else begin
            if (st_q == brg_pkg::ST_WAIT && ack_evt && wr_cnt_q < 8'(BUF_DEPTH)) begin
                wr_cnt_q <= wr_cnt_q + 8'h01;
            end
            if ((!rd_valid_q || rd_ready) && rd_ptr_q < wr_cnt_q && !busy) begin
                rd_ptr_q <= rd_ptr_q + 8'h01;
            end
        end
    end

    // Buffer storage in exchange order
    always_ff @(posedge clk) begin
        if (st_q == brg_pkg::ST_WAIT && ack_evt && wr_cnt_q < 8'(BUF_DEPTH)) begin
            buf_mem[wr_cnt_q] <= rx_byte;
        end
    end

    // Readback staging register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_valid_q <= 1'b0;
            rd_data_q  <= 8'h00;
        end else if (!rd_valid_q || rd_ready) begin
            rd_valid_q <= (rd_ptr_q < wr_cnt_q) && !busy;
            rd_data_q  <= buf_mem[rd_ptr_q];
        end
    end
    assign rd_valid = rd_valid_q;
    assign rd_data  = rd_data_q;

    // Shared slave select and general-purpose pins
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            logic       s1_q;          // Pin synchroniser stage 1
            logic       s2_q;          // Pin synchroniser stage 2
            logic       filt_q;        // Filtered pin level
            logic [3:0] gcnt_q;        // Stability counter
            logic       o_q;           // Pin output level
            logic       oe_q;          // Pin output enable
            logic [1:0] mode;          // Pin mode when general-purpose
            assign mode = gpio_cfg[2*gi +: 2];
            // Drive selection
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    o_q  <= 1'b1;
                    oe_q <= 1'b1;
                end else if (!gpio_en[gi]) begin
                    o_q  <= ~ss_q[gi];
                    oe_q <= 1'b1;
                end else if (mode == brg_pkg::PM_PUSH) begin
                    o_q  <= gpio_latch[gi];
                    oe_q <= 1'b1;
                end else if (mode == brg_pkg::PM_INPUT) begin
                    o_q  <= 1'b0;
                    oe_q <= 1'b0;
                end else begin
                    o_q  <= 1'b0;                          // Pull low only on zero
                    oe_q <= ~gpio_latch[gi];
                end
            end
            // Input synchroniser and glitch filter
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    s1_q   <= 1'b1;
                    s2_q   <= 1'b1;
                    filt_q <= 1'b1;
                    gcnt_q <= 4'h0;
                end else begin
                    s1_q <= slave_select_n_i[gi];
                    s2_q <= s1_q;
                    if (s2_q == filt_q) begin
                        gcnt_q <= 4'h0;
                    end else if (gcnt_q == 4'(brg_pkg::GLITCH_CYC - 1)) begin
                        filt_q <= s2_q;
                        gcnt_q <= 4'h0;
                    end else begin
                        gcnt_q <= gcnt_q + 4'h1;
                    end
                end
            end
            assign slave_select_n_o[gi]  = o_q;
            assign slave_select_n_oe[gi] = oe_q;
            assign gpio_in[gi]           = filt_q;
        end
    endgenerate

    // ---------------- Link clock domain ----------------
    logic        lrst1_q;              // Reset release stage 1
    logic        lrst_n_q;             // Link-domain reset
    logic        rq_s1_q;              // Request synchroniser stage 1
    logic        rq_s2_q;              // Request synchroniser stage 2
    logic        rq_seen_q;            // Last request level consumed
    logic        pol_s1_q;             // Polarity synchroniser stage 1
    logic        pol_s2_q;             // Polarity synchroniser stage 2
    logic        mi_s1_q;              // Input data stage 1
    logic        mi_s2_q;              // Input data stage 2
    logic        run_q;                // Byte being shifted
    logic        cpha_q;               // Phase of current byte
    logic [15:0] hp_q;                 // Half-period length
    logic [15:0] div_q;                // Half-period counter
    logic [3:0]  edge_q;               // Clock edge index
    logic        sclk_q;               // Serial clock level
    logic [7:0]  sh_q;                 // Outgoing shift register
    logic [7:0]  rx_q;                 // Incoming shift register
    logic [15:0] hp_sel;               // Half period for the setting

    assign rx_byte = rx_q;             // Stable once the ack toggle is seen
    assign serial_master_clock = sclk_q;
    assign mosi = sh_q[7];

    // Rate lookup from the setting byte
    always_comb begin
        unique case (cfg_q[brg_pkg::CFG_RATE_LSB +: 2])
            2'h0:    hp_sel = 16'(HP0);
            2'h1:    hp_sel = 16'(HP1);
            2'h2:    hp_sel = 16'(HP2);
            default: hp_sel = 16'(HP3);
        endcase
    end

    // Reset release and level synchronisers
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            lrst1_q  <= 1'b0;
            lrst_n_q <= 1'b0;
            rq_s1_q  <= 1'b0;
            rq_s2_q  <= 1'b0;
            pol_s1_q <= 1'b0;
            pol_s2_q <= 1'b0;
            mi_s1_q  <= 1'b0;
            mi_s2_q  <= 1'b0;
        end else begin
            lrst1_q  <= 1'b1;
            lrst_n_q <= lrst1_q;
            rq_s1_q  <= req_tgl_q;
            rq_s2_q  <= rq_s1_q;
            pol_s1_q <= cfg_q[brg_pkg::CFG_CPOL_BIT];
            pol_s2_q <= pol_s1_q;
            mi_s1_q  <= miso;
            mi_s2_q  <= mi_s1_q;
        end
    end

    // Byte shifter; setting and byte are held steady by the request handshake
    always_ff @(posedge link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            rq_seen_q <= 1'b0;
            ack_tgl_q <= 1'b0;
            run_q     <= 1'b0;
            cpha_q    <= 1'b0;
            hp_q      <= 16'h0001;
            div_q     <= 16'h0000;
            edge_q    <= 4'h0;
            sclk_q    <= 1'b0;
            sh_q      <= 8'hFF;
            rx_q      <= 8'h00;
        end else if (!run_q) begin
            sclk_q <= pol_s2_q;
            if (rq_s2_q != rq_seen_q) begin
                rq_seen_q <= rq_s2_q;
                run_q     <= 1'b1;
                cpha_q    <= cfg_q[brg_pkg::CFG_CPHA_BIT];
                hp_q      <= hp_sel;
                div_q     <= 16'h0000;
                edge_q    <= 4'h0;
                sh_q      <= tx_q;
            end
        end else if (div_q != hp_q - 16'h0001) begin
            div_q <= div_q + 16'h0001;
        end else begin
            div_q  <= 16'h0000;
            sclk_q <= ~sclk_q;
            edge_q <= edge_q + 4'h1;
            if (edge_q[0] == cpha_q) begin
                rx_q <= {rx_q[6:0], mi_s2_q};
            end else if (edge_q != 4'h0) begin
                sh_q <= {sh_q[6:0], 1'b1};
            end
            if (edge_q == 4'hF) begin
                run_q     <= 1'b0;
                ack_tgl_q <= ~ack_tgl_q;
            end
        end
    end
endmodule // brg_bridge

`default_nettype wire

// ==== test/brg_bridge_monitor.sv ====
// Checker for the bridge top: timing relations between its ports.
// Assumes it is bound to every brg_bridge; system clock domain only.
`timescale 1ns/1ps
`default_nettype none
module brg_bridge_monitor (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic       busy,
    input wire logic       int_n,
    input wire logic       rd_valid,
    input wire logic       rd_ready,
    input wire logic [7:0] rd_data,
    input wire logic [3:0] gpio_en,
    input wire logic [7:0] gpio_cfg,
    input wire logic [3:0] gpio_latch,
    input wire logic [3:0] gpio_in,
    input wire logic [3:0] slave_select_n_i,
    input wire logic [3:0] slave_select_n_o,
    input wire logic [3:0] slave_select_n_oe
);
    // Every check runs on clk and rests during reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_int_on_done: assert property ($fell(busy) |-> !int_n)
        else $error("interrupt missing after transfer");
    a_int_release: assert property ($rose(int_n) |-> !busy)
        else $error("interrupt cleared during transfer");
    a_select_held: assert property (busy && $past(busy, 3) |-> slave_select_n_o != 4'hF)
        else $error("no select low during transfer");
    a_select_end: assert property ($fell(busy) && gpio_en == 4'h0 |=> slave_select_n_o == 4'hF)
        else $error("select not released after transfer");
    a_select_drive: assert property (!gpio_en[3] |-> slave_select_n_oe[3])
        else $error("select pin not driven");
    a_push_pull: assert property (gpio_en[0] && gpio_cfg[1:0] == brg_pkg::PM_PUSH
        && $stable(gpio_latch[0]) && $stable(gpio_cfg[1:0]) && $stable(gpio_en[0])
        |-> slave_select_n_oe[0] && slave_select_n_o[0] == gpio_latch[0])
        else $error("push-pull pin not following latch");
    a_input_float: assert property (gpio_en[1] && gpio_cfg[3:2] == brg_pkg::PM_INPUT
        && $stable(gpio_cfg[3:2]) && $stable(gpio_en[1]) |-> !slave_select_n_oe[1])
        else $error("input-only pin driven");
    a_glitch_filter: assert property ($changed(gpio_in[1]) |->
        $past(slave_select_n_i[1], 3) == gpio_in[1] && $past(slave_select_n_i[1], 8) == gpio_in[1])
        else $error("short pulse reached filtered input");
    a_rd_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
        else $error("readback byte not held");
endmodule // brg_bridge_monitor
bind brg_bridge brg_bridge_monitor i_mon (
    .clk(clk), .arst_n(arst_n), .busy(busy), .int_n(int_n), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .gpio_en(gpio_en), .gpio_cfg(gpio_cfg),
    .gpio_latch(gpio_latch), .gpio_in(gpio_in), .slave_select_n_i(slave_select_n_i),
    .slave_select_n_o(slave_select_n_o), .slave_select_n_oe(slave_select_n_oe));
`default_nettype wire

// ==== test/brg_spi_slave.sv ====
// Behavioural SPI slave facing the bridge's serial master port.
// Assumes the bench gives it the mode and a resolved select level.
`timescale 1ns/1ps
`default_nettype none
module brg_spi_slave (
    input  wire logic sclk,
    input  wire logic mosi,
    input  wire logic ss_n,
    input  wire logic cpol,
    input  wire logic cpha,
    output logic      miso
);
    logic [7:0] rx_q[$];     // Bytes captured from the data-out line
    logic [7:0] sh;          // Incoming shift register
    logic [7:0] r;           // Reply byte now presented
    int         cnt;         // Shift edges in this selection
    int         ns;          // Sample edges in this selection
    int         idx;         // Bit position now presented
    logic       tick = 1'b0; // Changing level while released
    // Reply for byte position b of a selection
    function automatic logic [7:0] reply(input int b);
        return 8'h5A + 8'(b * 17);
    endfunction
    always #7 tick = ~tick;
    // A new selection restarts the counts
    always @(negedge ss_n) begin
        cnt = 0;
        ns = 0;
    end
    // Leading or trailing edge samples depending on phase
    always @(sclk) begin
        if (!ss_n) begin
            if ((sclk != cpol) ^ cpha) begin
                sh = {sh[6:0], mosi};
                ns = ns + 1;
                if (ns % 8 == 0) rx_q.push_back(sh);
            end else begin
                cnt = cnt + 1;
            end
        end
    end
    // Reply MSB first; released line never holds its last value
    always @* begin
        idx = (cnt > 0) ? cnt - int'(cpha) : 0;
        r = reply(idx / 8);
        miso = ss_n ? tick : r[7 - idx % 8];
    end
endmodule // brg_spi_slave
`default_nettype wire

// ==== test/brg_bridge_bench.sv ====
// Self-checking bench for the bridge: messages, SPI, readback, pins.
// Assumes the slave model, pull-ups on all select pins, 48 ns link clock.
`timescale 1ns/1ps
`default_nettype none
module brg_bridge_bench;
    logic clk = 1'b0, link_clk = 1'b0, arst_n = 1'b0;
    logic msg_valid, msg_ready, rd_valid, rd_ready, int_n, busy, sclk, mosi, miso, cpol, cpha;
    logic full = 1'b0;
    brg_pkg::brg_msg_s msg_in;
    logic [7:0] rd_data, gpio_cfg;
    logic [3:0] gpio_en, gpio_latch, gpio_in, ss_o, ss_oe, ext_en, ext_v, pin;
    int miscompares = 0;
    int checked = 0;
    // Pin level: design drive, else bench drive, else pull-up
    assign pin = (ss_oe & ss_o) | (~ss_oe & ext_en & ext_v) | (~ss_oe & ~ext_en);
    always #10 clk = ~clk;
    initial #3 forever #24 link_clk = ~link_clk;
    // Record any refusal on the message port
    always @(posedge clk) if (msg_valid && !msg_ready) full <= 1'b1;
    brg_bridge i_dut (.clk(clk), .arst_n(arst_n), .link_clk(link_clk),
        .msg_valid(msg_valid), .msg_ready(msg_ready), .msg_in(msg_in),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .int_n(int_n),
        .busy(busy), .serial_master_clock(sclk), .mosi(mosi), .miso(miso),
        .gpio_en(gpio_en), .gpio_cfg(gpio_cfg), .gpio_latch(gpio_latch),
        .gpio_in(gpio_in), .slave_select_n_i(pin), .slave_select_n_o(ss_o),
        .slave_select_n_oe(ss_oe));
    brg_spi_slave i_slave (.sclk(sclk), .mosi(mosi), .ss_n(&pin), .cpol(cpol),
        .cpha(cpha), .miso(miso));
    function automatic logic [7:0] reply(input int b);
        return 8'h5A + 8'(b * 17);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %0h, expected %0h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        if (miscompares == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One write message, bytes back to back, held until taken
    task automatic msg(input logic [7:0] b[$]);
        foreach (b[i]) begin
            msg_in = '{last: (i == b.size() - 1), data: b[i]};
            msg_valid = 1'b1;
            while (msg_ready !== 1'b1) cyc(1);
            cyc(1);
        end
        msg_valid = 1'b0;
        cyc(1);
    endtask
    // Transfer, then slave capture, readback and interrupt clear
    task automatic xfer(input logic [7:0] b[$]);
        int w = 0;
        msg(b);
        while (int_n !== 1'b0 && w < 90000) begin
            cyc(1);
            w++;
        end
        cyc(20);
        chk(int_n, 1'b0);
        chk(i_slave.rx_q.size(), b.size() - 1);
        for (int i = 1; i < b.size(); i++) chk(i_slave.rx_q[i - 1], b[i]);
        i_slave.rx_q.delete();
        rd_ready = 1'b1;
        for (int i = 0; i < b.size() - 1; i++) begin
            w = 0;
            while (rd_valid !== 1'b1 && w < 50) begin
                cyc(1);
                w++;
            end
            chk(rd_data, reply(i));
            cyc(1);
        end
        rd_ready = 1'b0;
        chk(rd_valid, 1'b0);
        msg('{brg_pkg::FN_CLR});
        cyc(5);
        chk(int_n, 1'b1);
    endtask
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            {cpol, cpha} = 2'(m);
            msg('{brg_pkg::FN_CFG, 8'(m << 2)});
            cyc(30);
            chk(sclk, cpol);
            xfer('{8'h01, 8'h3C, 8'hC3});
        end
    endtask
    task automatic t_fifo();
        logic [7:0] q[$];
        q = '{8'h08};
        repeat (20) q.push_back(8'hFF);
        xfer(q);
        chk(full, 1'b1);
    endtask
    task automatic t_gpio();
        {gpio_cfg, gpio_en, ext_en} = {8'h39, 4'h7, 4'h2};
        for (int v = 0; v < 2; v++) begin
            gpio_latch[0] = 1'(v);
            gpio_latch[2] = 1'(v);
            cyc(3);
            chk({ss_oe[0], ss_o[0]}, {1'b1, 1'(v)});
            chk({ss_oe[2], ss_o[2]}, {~1'(v), 1'b0});
        end
        chk(ss_oe[1], 1'b0);
        ext_v[1] = 1'b0;
        cyc(3);
        ext_v[1] = 1'b1;
        cyc(1);
        chk(gpio_in[1], 1'b1);
        ext_v[1] = 1'b0;
        cyc(20);
        chk(gpio_in[1], 1'b0);
        {gpio_en, ext_en} = 8'h00;
    endtask
    // Watchdog on a span well beyond the expected run
    initial begin
        #1000000;
        miscompares++;
        end_sim();
    end
    initial begin
        {msg_valid, rd_ready, cpol, cpha} = 4'h0;
        {msg_in, gpio_en, gpio_cfg, ext_en} = '0;
        {gpio_latch, ext_v} = 8'hFF;
        repeat (20) @(posedge clk);
        chk({int_n, busy, ss_o, ss_oe, mosi, sclk, msg_ready}, 13'h17FD);
        #1 arst_n = 1'b1;
        cyc(10);
        msg('{brg_pkg::FN_CFG, 8'h02});
        xfer('{8'h04, 8'hAA, 8'hBB});
        t_modes();
        t_fifo();
        t_gpio();
        end_sim();
    end
endmodule // brg_bridge_bench
`default_nettype wire
